// ==== hdl/iss_pkg.sv ====
`default_nettype none
package iss_pkg;
  // opcode patterns, 12-bit instruction words
  localparam logic [11:0] ISS_OP_INCSZ_MASK  = 12'hFC0;
  localparam logic [11:0] ISS_OP_INCSZ_VAL   = 12'h3C0;
  localparam logic [11:0] ISS_OP_SLEEP       = 12'h003;
  localparam logic [11:0] ISS_OP_NOP         = 12'h000;
  // instruction fields
  localparam int          ISS_DEST_BIT       = 5;
  localparam int          ISS_FADDR_W        = 5;
  localparam int          ISS_DATA_W         = 8;
  // register map (byte addresses)
  localparam logic [7:0]  ISS_REG_CTRL       = 8'h00;
  localparam logic [7:0]  ISS_REG_INSTR      = 8'h04;
  localparam logic [7:0]  ISS_REG_WREG       = 8'h08;
  localparam logic [7:0]  ISS_REG_STATUS     = 8'h0C;
  localparam logic [7:0]  ISS_REG_FILE_BASE  = 8'h80;
  // status bit positions
  localparam int          ISS_ST_PD_N        = 0;
  localparam int          ISS_ST_TO_N        = 1;
  localparam int          ISS_ST_SLEEP       = 2;
  localparam int          ISS_ST_SKIP        = 3;
  localparam int          ISS_ST_WAKE        = 4;
  // reset values
  localparam logic [7:0]  ISS_WREG_RST       = 8'h00;
  localparam logic [7:0]  ISS_WDT_RST        = 8'h00;
  localparam logic [7:0]  ISS_PRESC_RST      = 8'h00;
  // axi responses
  localparam logic [1:0]  ISS_RESP_OKAY      = 2'b00;
  localparam logic [1:0]  ISS_RESP_SLVERR    = 2'b10;
endpackage
`default_nettype wire

// ==== hdl/iss_exec_if.sv ====
`default_nettype none
interface iss_exec_if;
  logic [11:0] instr;
  logic        instr_valid;
  logic [7:0]  fdata;
  logic [7:0]  result;
  logic        wr_w;
  logic        wr_f;
  logic        skip;
  logic        sleep;
  modport core (output instr, output instr_valid, input fdata,
                input result, input wr_w, input wr_f, input skip,
                input sleep);
  modport dec  (input instr, input instr_valid, output fdata,
                output result, output wr_w, output wr_f,
                output skip, output sleep);
endinterface
`default_nettype wire

// ==== hdl/iss_decode.sv ====
`default_nettype none
module iss_decode
  import iss_pkg::*;
(
  // file register contents
  input  wire logic [7:0] fval,
  // decode interface
  iss_exec_if.dec         ex
);
  logic is_inc;
  logic [7:0] sum;
  // decode and compute
  always_comb begin
    is_inc    = ex.instr_valid &&
                ((ex.instr & ISS_OP_INCSZ_MASK) == ISS_OP_INCSZ_VAL);
    sum       = fval + 8'h01;
    ex.fdata  = fval;
    ex.result = sum;
    ex.wr_w   = is_inc && !ex.instr[ISS_DEST_BIT];
    ex.wr_f   = is_inc && ex.instr[ISS_DEST_BIT];
    ex.skip   = is_inc && (sum == 8'h00);
    ex.sleep  = ex.instr_valid && (ex.instr == ISS_OP_SLEEP);
  end
endmodule
`default_nettype wire

// ==== hdl/iss_core.sv ====
// Implementation choices: the address map and the AXI4-Lite register port.
`default_nettype none
// Summary of operation
// - pattern 0011 11df ffff increments file register f
// - d=0 writes working register, d=1 file register
// - zero result discards the prefetched next instruction
// - opcode 0000 0000 0011 enters sleep
// - sleep stops the instruction clock until wake
// - sleep sets active-low time-out flag to 1
// - sleep clears active-low power-down flag to 0
// - sleep zeroes watchdog counter and its prescaler
module iss_core
  import iss_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // wake request pin
  input  wire logic        wake_pin,
  // low power state
  output logic             osc_run,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // all checks below run on the core clock, off while in reset
  default clocking iss_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  iss_exec_if ex ();
  logic [7:0]  file_r [32];
  logic [7:0]  wreg_r;
  logic [11:0] instr_r;
  logic        ivalid_r;
  logic        skip_r;
  logic        sleep_r;
  logic        to_n_r;
  logic        pd_n_r;
  logic        wake_flag_r;
  logic [7:0]  wdt_r;
  logic [7:0]  presc_r;
  logic        wake_s1_r;
  logic        wake_s2_r;
  logic [7:0]  awaddr_r;
  logic        aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_have_r;
  logic        do_write;
  logic        issue;
  logic [4:0]  faddr;
  logic [31:0] rd_nxt;
  logic        rd_ok;

  assign faddr          = instr_r[ISS_FADDR_W-1:0];
  assign ex.instr       = skip_r ? ISS_OP_NOP : instr_r;
  assign ex.instr_valid = ivalid_r && !sleep_r;

  iss_decode u_dec (
    .fval (file_r[faddr]),
    .ex   (ex)
  );

  // wake pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_pin;
      wake_s2_r <= wake_s1_r;
    end
  end

  // write channel capture, address and data in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign do_write      = aw_have_r && w_have_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ISS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r[7] || awaddr_r == ISS_REG_CTRL ||
                         awaddr_r == ISS_REG_INSTR ||
                         awaddr_r == ISS_REG_WREG) ?
                        ISS_RESP_OKAY : ISS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software issues one instruction by writing the instruction register
  assign issue = do_write && awaddr_r == ISS_REG_INSTR && wstrb_r[0];

  // instruction pipeline: current word, skip marker
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_r  <= ISS_OP_NOP;
      ivalid_r <= 1'b0;
      skip_r   <= 1'b0;
    end else begin
      ivalid_r <= issue && !sleep_r; // no cycles while asleep
      if (issue) begin
        instr_r <= {wdata_r[11:8] & {4{wstrb_r[1]}}, wdata_r[7:0]};
      end
      if (ex.instr_valid) begin
        skip_r <= ex.skip;
      end
    end
  end

  // file registers
  always_ff @(posedge sys_clk) begin
    if (ex.wr_f) begin
      file_r[faddr] <= ex.result;
    end else if (do_write && awaddr_r[7] && wstrb_r[0]) begin
      file_r[awaddr_r[6:2]] <= wdata_r[7:0];
    end
  end

  // working register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wreg_r <= ISS_WREG_RST;
    end else if (ex.wr_w) begin
      wreg_r <= ex.result;
    end else if (do_write && awaddr_r == ISS_REG_WREG && wstrb_r[0]) begin
      wreg_r <= wdata_r[7:0];
    end
  end

  // sleep state, power flags, watchdog; wake flag only set by pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_r     <= 1'b0;
      to_n_r      <= 1'b1;
      pd_n_r      <= 1'b1;
      wdt_r       <= ISS_WDT_RST;
      presc_r     <= ISS_PRESC_RST;
      wake_flag_r <= 1'b0;
    end else begin
      if (ex.sleep) begin
        sleep_r <= 1'b1;
        to_n_r  <= 1'b1;
        pd_n_r  <= 1'b0;
        wdt_r   <= ISS_WDT_RST;
        presc_r <= ISS_PRESC_RST;
      end else begin
        if (sleep_r && wake_s2_r) begin
          sleep_r <= 1'b0;
        end
        if (!sleep_r) begin
          {wdt_r, presc_r} <= {wdt_r, presc_r} + 16'h0001;
        end
      end
      if (sleep_r && wake_s2_r) begin
        wake_flag_r <= 1'b1;
      end else if (do_write && awaddr_r == ISS_REG_CTRL && wstrb_r[0] &&
                   wdata_r[0]) begin
        wake_flag_r <= 1'b0;
      end
    end
  end

  assign osc_run = !sleep_r;

  // read channel
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr[7]) begin
      rd_nxt[7:0] = file_r[s_axi_araddr[6:2]];
    end else begin
      unique case (s_axi_araddr)
        ISS_REG_CTRL:   rd_nxt = 32'h0000_0000;
        ISS_REG_INSTR:  rd_nxt[11:0] = instr_r;
        ISS_REG_WREG:   rd_nxt[7:0] = wreg_r;
        ISS_REG_STATUS: begin
          rd_nxt[ISS_ST_PD_N]  = pd_n_r;
          rd_nxt[ISS_ST_TO_N]  = to_n_r;
          rd_nxt[ISS_ST_SLEEP] = sleep_r;
          rd_nxt[ISS_ST_SKIP]  = skip_r;
          rd_nxt[ISS_ST_WAKE]  = wake_flag_r;
          rd_nxt[15:8]         = wdt_r;
        end
        default:        rd_ok = 1'b0;
      endcase
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ISS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_nxt;
      s_axi_rresp  <= rd_ok ? ISS_RESP_OKAY : ISS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks on the execution path, operand taken from the decoder side
  a_inc_w_dest: assert property (
    ex.wr_w |=> wreg_r == $past(ex.fdata) + 8'h01)
    else $error("increment to working register wrong");
  a_skip_nop: assert property (
    skip_r && ex.instr_valid |->
      !ex.wr_w && !ex.wr_f && !ex.sleep && !ex.skip)
    else $error("skipped slot not a no-op");
  a_skip_zero: assert property (
    ex.skip |-> ex.result == 8'h00 && ex.fdata == 8'hFF)
    else $error("skip without zero result");
  a_sleep_flags: assert property (
    ex.sleep |=> to_n_r && !pd_n_r && wdt_r == 8'h00 && presc_r == 8'h00)
    else $error("sleep flags or watchdog wrong");
  a_sleep_osc: assert property (
    ex.sleep |=> !osc_run && !ex.instr_valid)
    else $error("oscillator still running");
  a_sleep_decode: assert property (
    ex.sleep |-> instr_r == ISS_OP_SLEEP && !skip_r)
    else $error("sleep decoded from wrong opcode");
  a_sleep_pd_hold: assert property (
    sleep_r && !wake_s2_r |=> !pd_n_r && sleep_r)
    else $error("power-down flag lost in sleep");
  a_wake_kept: assert property (
    ex.sleep && !(sleep_r && wake_s2_r) |=> wake_flag_r == $past(wake_flag_r))
    else $error("wake flag changed by sleep");
  a_inc_decode: assert property (
    (ex.wr_w || ex.wr_f) |-> ex.instr[11:6] == 6'h0F)
    else $error("increment decoded from wrong opcode");
  c_skip: cover property (ex.skip);
  c_inc_f: cover property (ex.wr_f && !ex.skip);
  c_sleep_wake: cover property (sleep_r ##1 !sleep_r);
endmodule
`default_nettype wire

// ==== bench/test_increment_skip_sleep_exec.sv ====
`default_nettype none
module test_increment_skip_sleep_exec import iss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        rst_n;
  logic        wake_pin;
  logic        osc_run;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0;
  int          compares = 0;
  localparam logic [31:0] ST_RST = 32'h3;
  localparam logic [31:0] ST_SLP = 32'h6;
  localparam logic [31:0] M_SKIP = 32'h8;
  localparam logic [31:0] M_WAKE = 32'h10;

  iss_core dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .wake_pin(wake_pin),
    .osc_run(osc_run), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // 40 mhz clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // compare one word and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // axi4-lite write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit aw_ok = 0;
    bit w_ok = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge sys_clk);
      aw_ok |= s_axi_awvalid && s_axi_awready;
      w_ok |= s_axi_wvalid && s_axi_wready;
      @(posedge sys_clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(negedge sys_clk);
      r = s_axi_bresp;
    end while (s_axi_bvalid !== 1'b1);
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask

  // axi4-lite read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge sys_clk);
    end while (s_axi_arready !== 1'b1);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge sys_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (s_axi_rvalid !== 1'b1);
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask

  // read a register and compare the masked word
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e, input string what);
    axi_rd(a, rd, rsp);
    chk(rd & m, e, what);
  endtask

  // issue one instruction word
  task automatic issue(input logic [11:0] i);
    axi_wr(ISS_REG_INSTR, {20'h0, i}, rsp);
  endtask

  function automatic logic [7:0] fa(input int f);
    return 8'(ISS_REG_FILE_BASE + f * 4);
  endfunction

  // print counts and verdict, end the run
  task automatic summarize;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end

  // main sequence
  initial begin
    {rst_n, wake_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(ISS_REG_STATUS, 32'h1F, ST_RST, "reset status");
    rd_chk(ISS_REG_WREG, 32'hFF, 32'h00, "reset w");
    axi_wr(fa(3), 32'h41, rsp);
    axi_wr(fa(31), 32'h10, rsp);
    axi_wr(fa(5), 32'hFF, rsp);
    issue(12'h383);
    rd_chk(fa(3), 32'hFF, 32'h41, "near miss f");
    rd_chk(ISS_REG_WREG, 32'hFF, 32'h00, "near miss w");
    issue(12'h3C3);
    rd_chk(ISS_REG_WREG, 32'hFF, 32'h42, "inc to w");
    rd_chk(fa(3), 32'hFF, 32'h41, "f kept");
    rd_chk(ISS_REG_STATUS, M_SKIP, 32'h0, "no skip");
    issue(12'h3FF);
    rd_chk(fa(31), 32'hFF, 32'h11, "inc f31");
    rd_chk(ISS_REG_WREG, 32'hFF, 32'h42, "w kept");
    issue(12'h3E5);
    rd_chk(fa(5), 32'hFF, 32'h00, "wrap f5");
    rd_chk(ISS_REG_STATUS, M_SKIP, M_SKIP, "skip set");
    issue(12'h3DF);
    rd_chk(ISS_REG_WREG, 32'hFF, 32'h42, "skipped w");
    rd_chk(fa(31), 32'hFF, 32'h11, "skipped f");
    rd_chk(ISS_REG_STATUS, M_SKIP, 32'h0, "skip done");
    issue(12'h3DF);
    rd_chk(ISS_REG_WREG, 32'hFF, 32'h12, "after skip");
    axi_rd(8'h40, rd, rsp);
    chk({30'h0, rsp}, {30'h0, ISS_RESP_SLVERR}, "unmapped rd");
    axi_wr(8'h44, 32'h1, rsp);
    chk({30'h0, rsp}, {30'h0, ISS_RESP_SLVERR}, "unmapped wr");
    // let the watchdog reach a nonzero count so that sleep must clear it
    repeat (300) @(posedge sys_clk);
    axi_rd(ISS_REG_STATUS, rd, rsp);
    chk({31'h0, |rd[15:8]}, 32'h1, "wdt running");
    issue(ISS_OP_SLEEP);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, osc_run}, 32'h0, "osc stop");
    rd_chk(ISS_REG_STATUS, 32'hFF1F, ST_SLP, "sleep st");
    issue(12'h3C3);
    rd_chk(ISS_REG_WREG, 32'hFF, 32'h12, "sleep ign");
    @(posedge sys_clk);
    wake_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wake_pin <= 1'b0;
    @(negedge sys_clk);
    chk({31'h0, osc_run}, 32'h1, "woken");
    repeat (300) @(posedge sys_clk);
    issue(ISS_OP_SLEEP);
    rd_chk(ISS_REG_STATUS, M_WAKE, M_WAKE, "wake kept");
    rd_chk(ISS_REG_STATUS, 32'hFF03, 32'h2, "wdt clr");
    axi_wr(ISS_REG_CTRL, 32'h1, rsp);
    rd_chk(ISS_REG_STATUS, M_WAKE, 32'h0, "wake cleared");
    summarize();
  end
endmodule
`default_nettype wire
